// File: hbs_pkg.sv
// constants and types shared by the handshake byte sequencer
package hbs_pkg;
   // one internal converter clock period spans two master clocks
   localparam int MCLK_PERIOD_NS    = 100;
   localparam int INT_CLK_PERIOD_NS = 200;
   localparam int PHASES_PER_PERIOD = INT_CLK_PERIOD_NS / MCLK_PERIOD_NS;
   // byte select indices
   localparam logic [1:0] SEL_HIGH = 2'h0;
   localparam logic [1:0] SEL_MID  = 2'h1;
   localparam logic [1:0] SEL_LOW  = 2'h2;
   // high byte field positions
   localparam int HB_SIGN_POS = 7;
   localparam int HB_OVER_POS = 6;
   // fifo item layout: {last, select index, byte}
   localparam int ITEM_LAST_POS = 10;
   localparam int ITEM_SEL_LSB  = 8;
   localparam int ITEM_WIDTH    = 11;
   // reset values
   localparam logic [2:0] SEL_N_RESET   = 3'h7;
   localparam logic       STROBE_RESET  = 1'h1;
   localparam logic [7:0] DATA_RESET    = 8'h00;
   typedef enum logic [2:0] {
      HS_IDLE, HS_FILL, HS_WAIT, HS_PRESENT, HS_LOAD, HS_HOLD, HS_DROP
   } hbs_state_t;
endpackage

// File: hbs_stream_if.sv
// valid/ready byte stream between the loader and the sequencer
`timescale 1ns/1ns
`default_nettype none
interface hbs_stream_if #(parameter int WIDTH = 11);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: hbs_fifo.sv
// byte fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module hbs_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 8
) (
   input  wire logic   clk,
   input  wire logic   rst_n,
   hbs_stream_if.snk   wr,
   hbs_stream_if.src   rd
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wptr_reg, wptr_next;
   logic [AW-1:0]    rptr_reg, rptr_next;
   logic [AW:0]      count_reg, count_next;
   logic             push;
   logic             pop;

   // honest full and empty from the occupancy count
   assign wr.ready = (count_reg != (AW+1)'(DEPTH));
   assign rd.valid = (count_reg != '0);
   assign rd.data  = mem[rptr_reg];
   assign push     = wr.valid & wr.ready;
   assign pop      = rd.valid & rd.ready;

   // pointer and count update
   always_comb begin
      wptr_next  = wptr_reg;
      rptr_next  = rptr_reg;
      count_next = count_reg;
      if (push) begin
         wptr_next = (wptr_reg == AW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
      end
      if (pop) begin
         rptr_next = (rptr_reg == AW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
      end
      if (push & ~pop) begin
         count_next = count_reg + 1'b1;
      end else if (pop & ~push) begin
         count_next = count_reg - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr_reg  <= '0;
         rptr_reg  <= '0;
         count_reg <= '0;
      end else begin
         wptr_reg  <= wptr_next;
         rptr_reg  <= rptr_next;
         count_reg <= count_next;
      end
   end

   // storage has no reset; contents are only read while counted valid
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wptr_reg] <= wr.data;
      end
   end
endmodule
`default_nettype wire

// File: hbs_sequencer.sv
// handshake output byte sequencer of the converter digital section
`timescale 1ns/1ns
`default_nettype none
module hbs_sequencer
   import hbs_pkg::*;
#(
   parameter int RESULT_BITS = 16,
   parameter int FIFO_DEPTH  = 8
) (
   input  wire logic        MCLK,
   input  wire logic        NRST,
   input  wire logic        MODE,
   input  wire logic        CONV_DONE,
   input  wire logic        CONV_SIGN,
   input  wire logic        CONV_OVER,
   input  wire logic [15:0] CONV_BITS,
   input  wire logic        RECEIVER_READY_IN,
   input  wire logic        CS_LOAD_STROBE_N_I,
   output logic             CS_LOAD_STROBE_N_O,
   output logic             CS_LOAD_STROBE_N_OE,
   input  wire logic        HIGH_BYTE_SELECT_N_I,
   output logic             HIGH_BYTE_SELECT_N_O,
   output logic             HIGH_BYTE_SELECT_N_OE,
   input  wire logic        MIDDLE_BYTE_SELECT_N_I,
   output logic             MIDDLE_BYTE_SELECT_N_O,
   output logic             MIDDLE_BYTE_SELECT_N_OE,
   input  wire logic        LOW_BYTE_SELECT_N_I,
   output logic             LOW_BYTE_SELECT_N_O,
   output logic             LOW_BYTE_SELECT_N_OE,
   output logic [7:0]       DATA_O,
   output logic             DATA_OE,
   output logic             HANDSHAKE_ACTIVE
);
   localparam logic WIDE = (RESULT_BITS == 16);

   hbs_stream_if #(.WIDTH(ITEM_WIDTH)) fill_s ();
   hbs_stream_if #(.WIDTH(ITEM_WIDTH)) drain_s ();

   hbs_fifo #(.WIDTH(ITEM_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk   (MCLK),
      .rst_n (NRST),
      .wr    (fill_s),
      .rd    (drain_s)
   );

   hbs_state_t  state_reg, state_next;
   logic        phase_reg, phase_next;
   logic        mode_prev_reg, mode_prev_next;
   logic        sign_reg, sign_next;
   logic        over_reg, over_next;
   logic [15:0] bits_reg, bits_next;
   logic [1:0]  fill_idx_reg, fill_idx_next;
   logic        last_reg, last_next;
   logic [2:0]  sel_n_reg, sel_n_next;
   logic        strobe_n_reg, strobe_n_next;
   logic [7:0]  data_reg, data_next;
   logic        data_oe_reg, data_oe_next;
   logic        rise;
   logic        fall;
   logic        sen_seen;
   logic        active;
   logic        mode_rise;
   logic [1:0]  fill_last_idx;
   logic [2:0]  sel_in_n;

   // phase 0 marks an internal rising edge, phase 1 a falling edge
   assign rise      = ~phase_reg;
   assign fall      = phase_reg;
   assign sen_seen  = fall & RECEIVER_READY_IN;
   assign active    = (state_reg != HS_IDLE);
   assign mode_rise = MODE & ~mode_prev_reg;
   assign sel_in_n  = {LOW_BYTE_SELECT_N_I, MIDDLE_BYTE_SELECT_N_I, HIGH_BYTE_SELECT_N_I};
   assign fill_last_idx = SEL_LOW;

   // byte image of the latched result
   function automatic logic [7:0] byte_of(input logic [1:0] idx);
      logic [7:0] b;
      b = DATA_RESET;
      case (idx)
         SEL_HIGH: begin
            b[HB_SIGN_POS] = sign_reg;
            b[HB_OVER_POS] = over_reg;
            if (!WIDE) begin
               b[5:0] = bits_reg[13:8];
            end
         end
         SEL_MID: b = bits_reg[15:8];
         SEL_LOW: b = bits_reg[7:0];
         default: b = DATA_RESET;
      endcase
      return b;
   endfunction

   // loader side: pushes the bytes in send order into the fifo
   always_comb begin
      fill_s.valid = (state_reg == HS_FILL);
      fill_s.data  = {(fill_idx_reg == fill_last_idx), fill_idx_reg, byte_of(fill_idx_reg)};
   end

   // latch, phase and mode edge tracking
   always_comb begin
      phase_next     = ~phase_reg;
      mode_prev_next = MODE;
      sign_next      = sign_reg;
      over_next      = over_reg;
      bits_next      = bits_reg;
      // results finishing during handshake are simply not latched
      if (!active && CONV_DONE) begin
         sign_next = CONV_SIGN;
         over_next = CONV_OVER;
         bits_next = CONV_BITS;
      end
   end

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         phase_reg     <= 1'b0;
         mode_prev_reg <= 1'b0;
         sign_reg      <= 1'b0;
         over_reg      <= 1'b0;
         bits_reg      <= 16'h0000;
      end else begin
         phase_reg     <= phase_next;
         mode_prev_reg <= mode_prev_next;
         sign_reg      <= sign_next;
         over_reg      <= over_next;
         bits_reg      <= bits_next;
      end
   end

   // handshake sequencing
   always_comb begin
      state_next    = state_reg;
      fill_idx_next = fill_idx_reg;
      last_next     = last_reg;
      sel_n_next    = sel_n_reg;
      strobe_n_next = strobe_n_reg;
      data_next     = data_reg;
      data_oe_next  = data_oe_reg;
      drain_s.ready = 1'b0;
      case (state_reg)
         HS_IDLE: begin
            // direct access: chip select and byte select sensed as inputs
            data_oe_next = 1'b0;
            if (!MODE && !CS_LOAD_STROBE_N_I && (sel_in_n != 3'h7)) begin
               data_oe_next = 1'b1;
               data_next    = !HIGH_BYTE_SELECT_N_I ? byte_of(SEL_HIGH) :
                              !MIDDLE_BYTE_SELECT_N_I ? byte_of(SEL_MID) : byte_of(SEL_LOW);
            end
            // entry on the latch edge, or at once on a mode rise
            if ((CONV_DONE && MODE) || mode_rise) begin
               state_next    = HS_FILL;
               fill_idx_next = SEL_HIGH;
               sel_n_next    = SEL_N_RESET;
               strobe_n_next = STROBE_RESET;
               data_oe_next  = 1'b0;
            end
         end
         HS_FILL: begin
            // stalls while the fifo is full
            if (fill_s.ready) begin
               if (fill_idx_reg == fill_last_idx) begin
                  state_next = HS_WAIT;
               end else begin
                  fill_idx_next = (WIDE && fill_idx_reg == SEL_HIGH) ? SEL_MID : SEL_LOW;
               end
            end
         end
         HS_WAIT: begin
            if (sen_seen) begin
               state_next = HS_PRESENT;
            end
         end
         HS_PRESENT, HS_DROP: begin
            // both are rising-edge cycles: half a clock after the off edge
            sel_n_next = SEL_N_RESET;
            if (state_reg == HS_DROP && last_reg) begin
               state_next = HS_IDLE;
            end else if (drain_s.valid) begin
               drain_s.ready = 1'b1;
               sel_n_next[drain_s.data[ITEM_SEL_LSB +: 2]] = 1'b0;
               last_next     = drain_s.data[ITEM_LAST_POS];
               data_next     = drain_s.data[7:0];
               data_oe_next  = 1'b1;
               strobe_n_next = 1'b0;
               state_next    = HS_LOAD;
            end else begin
               state_next = HS_IDLE;
            end
         end
         HS_LOAD: begin
            // strobe spans one full internal period, rise to rise
            if (rise) begin
               strobe_n_next = 1'b1;
               state_next    = HS_HOLD;
            end
         end
         HS_HOLD: begin
            // select and data stay put while the receiver is busy
            if (sen_seen) begin
               data_oe_next = 1'b0;
               state_next   = HS_DROP;
            end
         end
         default: state_next = HS_IDLE;
      endcase
   end

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         state_reg    <= HS_IDLE;
         fill_idx_reg <= SEL_HIGH;
         last_reg     <= 1'b0;
         sel_n_reg    <= SEL_N_RESET;
         strobe_n_reg <= STROBE_RESET;
         data_reg     <= DATA_RESET;
         data_oe_reg  <= 1'b0;
      end else begin
         state_reg    <= state_next;
         fill_idx_reg <= fill_idx_next;
         last_reg     <= last_next;
         sel_n_reg    <= sel_n_next;
         strobe_n_reg <= strobe_n_next;
         data_reg     <= data_next;
         data_oe_reg  <= data_oe_next;
      end
   end

   // pin drivers: strobe and selects float only when idle with mode low, middle select always for narrow results; data follows data_oe_reg
   assign CS_LOAD_STROBE_N_O      = strobe_n_reg;
   assign HIGH_BYTE_SELECT_N_O    = sel_n_reg[SEL_HIGH];
   assign MIDDLE_BYTE_SELECT_N_O  = sel_n_reg[SEL_MID];
   assign LOW_BYTE_SELECT_N_O     = sel_n_reg[SEL_LOW];
   assign CS_LOAD_STROBE_N_OE     = active | MODE;
   assign HIGH_BYTE_SELECT_N_OE   = active | MODE;
   assign MIDDLE_BYTE_SELECT_N_OE = WIDE & (active | MODE);
   assign LOW_BYTE_SELECT_N_OE    = active | MODE;
   assign DATA_O                  = data_reg;
   assign DATA_OE                 = data_oe_reg;
   assign HANDSHAKE_ACTIVE        = active;
endmodule
`default_nettype wire

// File: hbs_rx_model.sv
// receiver model: takes a byte on load strobe release, then stalls
`timescale 1ns/1ns
`default_nettype none
module hbs_rx_model
   import hbs_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       strobe_n,
   input  wire logic       high_n,
   input  wire logic       mid_n,
   input  wire logic       low_n,
   input  wire logic [7:0] data,
   input  wire logic [7:0] stall,
   input  wire logic       hold,
   output logic            ready
);
   logic       busy;
   logic       strobe_q;
   logic [7:0] wait_cnt;
   logic [9:0] got[$];
   // ready only while the buffer is free
   assign ready = !hold && !busy;
   // one process owns the buffer: fills at once on strobe release so the
   // next ready sample already sees it, empties after the stall count
   always @(posedge clk or negedge rst_n or posedge strobe_n) begin
      if (!rst_n) begin
         busy     <= 1'b0;
         wait_cnt <= 8'h00;
      end else if (strobe_n && !strobe_q) begin
         got.push_back({!high_n ? SEL_HIGH : !mid_n ? SEL_MID : SEL_LOW, data});
         busy     <= (stall != 8'h00);
         wait_cnt <= stall;
      end else if (wait_cnt > 8'h01) begin
         wait_cnt <= wait_cnt - 8'h01;
      end else if (wait_cnt == 8'h01) begin
         busy     <= 1'b0;
         wait_cnt <= 8'h00;
      end
      strobe_q <= strobe_n;
   end
endmodule
`default_nettype wire

// File: hbs_sequencer_monitor.sv
// port assertions for the byte sequencer
`timescale 1ns/1ns
`default_nettype none
module hbs_sequencer_monitor (
   input wire logic MCLK,
   input wire logic NRST,
   input wire logic MODE,
   input wire logic CONV_DONE,
   input wire logic RECEIVER_READY_IN,
   input wire logic CS_LOAD_STROBE_N_O,
   input wire logic CS_LOAD_STROBE_N_OE,
   input wire logic HIGH_BYTE_SELECT_N_O,
   input wire logic HIGH_BYTE_SELECT_N_OE,
   input wire logic MIDDLE_BYTE_SELECT_N_O,
   input wire logic LOW_BYTE_SELECT_N_O,
   input wire logic LOW_BYTE_SELECT_N_OE,
   input wire logic DATA_OE,
   input wire logic HANDSHAKE_ACTIVE
);
   // short aliases keep the properties readable
   wire logic stb = CS_LOAD_STROBE_N_O;
   wire logic hi  = HIGH_BYTE_SELECT_N_O;
   wire logic mi  = MIDDLE_BYTE_SELECT_N_O;
   wire logic lo  = LOW_BYTE_SELECT_N_O;
   wire logic rdy = RECEIVER_READY_IN;
   wire logic oes = CS_LOAD_STROBE_N_OE && HIGH_BYTE_SELECT_N_OE && LOW_BYTE_SELECT_N_OE;
   default clocking @(posedge MCLK); endclocking
   default disable iff (!NRST);
   // entry, drive and strobe shape
   property p_out; (MODE || HANDSHAKE_ACTIVE) |-> oes; endproperty
   a_out: assert property (p_out) else $error("lines not driven");
   property p_entry; CONV_DONE && MODE && !HANDSHAKE_ACTIVE |=> HANDSHAKE_ACTIVE; endproperty
   a_entry: assert property (p_entry) else $error("no entry");
   property p_strobe; $fell(stb) |=> !stb ##1 stb; endproperty
   a_strobe: assert property (p_strobe) else $error("strobe width");
   property p_byte; $fell(stb) |-> DATA_OE && (!hi || !mi || !lo); endproperty
   a_byte: assert property (p_byte) else $error("strobe without byte");
   property p_switch; HANDSHAKE_ACTIVE && $fell(DATA_OE) |=> $changed({hi, mi, lo}); endproperty
   a_switch: assert property (p_switch) else $error("select not switched");
   property p_sel; $fell(hi) |=> !hi [*3]; endproperty
   a_sel: assert property (p_sel) else $error("select too short");
   // ready low stalls the strobe and holds the byte; exit levels
   property p_gate; !rdy [*3] |=> !$fell(stb); endproperty
   a_gate: assert property (p_gate) else $error("byte without ready");
   property p_hold; (!rdy [*3]) ##0 (DATA_OE && stb) |=> DATA_OE && $stable({hi, mi, lo}); endproperty
   a_hold: assert property (p_hold) else $error("byte not held");
   property p_exit; $fell(HANDSHAKE_ACTIVE) |-> hi && mi && lo && stb && CS_LOAD_STROBE_N_OE == MODE;
   endproperty
   a_exit: assert property (p_exit) else $error("bad exit levels");
   c_strobe: cover property ($fell(stb));
   c_stall: cover property ((DATA_OE && !rdy) [*3]);
   c_exit: cover property ($fell(HANDSHAKE_ACTIVE));
endmodule
bind hbs_sequencer hbs_sequencer_monitor u_hbs_sequencer_monitor (.*);
`default_nettype wire

// File: tb.sv
// self-checking bench: sequencer against a receiver model
`timescale 1ns/1ns
`default_nettype none
module tb;
   import hbs_pkg::*;
   logic        mclk, nrst, mode, done, sign, over, hold, cs_n, hi_n, lo_n;
   logic [15:0] bits;
   logic [7:0]  stall, data_o;
   logic        cs_o, cs_oe, hi_o, hi_oe, mi_o, mi_oe, lo_o, lo_oe, data_oe, active;
   wire logic   ready;
   wire logic   cs_pin = cs_oe ? cs_o : cs_n;
   wire logic   hi_pin = hi_oe ? hi_o : hi_n;
   wire logic   mi_pin = mi_oe ? mi_o : 1'b1;
   wire logic   lo_pin = lo_oe ? lo_o : lo_n;
   // released bus shows the inverse so stale data never looks valid
   wire logic [7:0] bus = data_oe ? data_o : ~data_o;
   int          error_cnt, checks;
   hbs_sequencer #(.RESULT_BITS(16), .FIFO_DEPTH(8)) u_hbs_sequencer (
      .MCLK(mclk), .NRST(nrst), .MODE(mode), .CONV_DONE(done), .CONV_SIGN(sign),
      .CONV_OVER(over), .CONV_BITS(bits), .RECEIVER_READY_IN(ready),
      .CS_LOAD_STROBE_N_I(cs_pin), .CS_LOAD_STROBE_N_O(cs_o), .CS_LOAD_STROBE_N_OE(cs_oe),
      .HIGH_BYTE_SELECT_N_I(hi_pin), .HIGH_BYTE_SELECT_N_O(hi_o), .HIGH_BYTE_SELECT_N_OE(hi_oe),
      .MIDDLE_BYTE_SELECT_N_I(mi_pin), .MIDDLE_BYTE_SELECT_N_O(mi_o),
      .MIDDLE_BYTE_SELECT_N_OE(mi_oe), .LOW_BYTE_SELECT_N_I(lo_pin),
      .LOW_BYTE_SELECT_N_O(lo_o), .LOW_BYTE_SELECT_N_OE(lo_oe), .DATA_O(data_o),
      .DATA_OE(data_oe), .HANDSHAKE_ACTIVE(active));
   hbs_rx_model u_hbs_rx_model (.clk(mclk), .rst_n(nrst), .strobe_n(cs_pin), .high_n(hi_pin),
      .mid_n(mi_pin), .low_n(lo_pin), .data(bus), .stall(stall), .hold(hold), .ready(ready));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      if (error_cnt == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic conv(input logic s, input logic o, input logic [15:0] b);
      @(negedge mclk);
      {done, sign, over, bits} = {1'b1, s, o, b};
      @(negedge mclk);
      done = 1'b0;
   endtask
   // bounded wait for the sequence to end
   task automatic finish_wait();
      for (int n = 0; n < 600 && active !== 1'b0; n++) @(negedge mclk);
      chk(active, 1'b0);
   endtask
   task automatic chk_bytes(input logic [7:0] h, input logic [15:0] b);
      chk(u_hbs_rx_model.got.size(), 3);
      chk(u_hbs_rx_model.got[0], {SEL_HIGH, h});
      chk(u_hbs_rx_model.got[1], {SEL_MID, b[15:8]});
      chk(u_hbs_rx_model.got[2], {SEL_LOW, b[7:0]});
      u_hbs_rx_model.got.delete();
   endtask
   // mode held high, a second result lands mid-sequence and is lost;
   // mode rises with the first result so the rise sends that result
   task automatic t_mode_high();
      @(negedge mclk);
      {mode, done, sign, over, bits} = {1'b1, 1'b1, 1'b1, 1'b0, 16'hA5C3};
      @(negedge mclk);
      done = 1'b0;
      chk(active, 1'b1);
      conv(1'b0, 1'b1, 16'h1234);
      finish_wait();
      chk_bytes(8'h80, 16'hA5C3);
      chk({cs_oe, cs_o, hi_o}, 3'h7);
      conv(1'b0, 1'b1, 16'h0F0F);
      chk(active, 1'b1);
      finish_wait();
      chk_bytes(8'h40, 16'h0F0F);
   endtask
   // mode edge while ready is low, mode dropped mid-sequence, slow receiver
   task automatic t_mode_edge();
      mode = 1'b0;
      conv(1'b1, 1'b1, 16'hBEEF);
      chk(active, 1'b0);
      {hold, stall, mode} = {1'b1, 8'h06, 1'b1};
      @(negedge mclk);
      chk(active, 1'b1);
      mode = 1'b0;
      repeat (8) @(negedge mclk);
      chk({data_oe, cs_pin}, 2'h1);
      chk(active, 1'b1);
      hold = 1'b0;
      finish_wait();
      chk_bytes(8'hC0, 16'hBEEF);
      chk({cs_oe, hi_oe, lo_oe}, 3'h0);
   endtask
   // direct mode: selects act as inputs, high byte wins over low
   task automatic t_direct();
      {cs_n, lo_n} = 2'h0;
      repeat (2) @(negedge mclk);
      chk({data_oe, data_o}, 9'h1EF);
      hi_n = 1'b0;
      repeat (2) @(negedge mclk);
      chk({data_oe, data_o}, 9'h1C0);
      {cs_n, hi_n, lo_n} = 3'h7;
      repeat (2) @(negedge mclk);
      chk(data_oe, 1'b0);
   endtask
   initial begin
      {nrst, mode, done, sign, over, hold, bits, stall} = '0;
      {cs_n, hi_n, lo_n} = 3'h7;
      repeat (12) @(negedge mclk);
      chk({active, data_oe, hi_oe, cs_oe}, 4'h0);
      nrst = 1'b1;
      t_mode_high();
      t_mode_edge();
      t_direct();
      report_and_stop();
   end
   // watchdog at 20000 cycles, far beyond the hundred or so cycles needed
   initial begin
      #2000000;
      error_cnt++;
      report_and_stop();
   end
endmodule
`default_nettype wire
